// *** design/sysctl_pkg.sv ***
// Package: register map, field layout and carrier types of the system control block
package sysctl_pkg;

  // ********************************************************************
  // Register byte offsets
  // ********************************************************************
  localparam logic [7:0] BANK_EN_OFF = 8'h00;
  localparam logic [7:0] BANK_DIS_OFF = 8'h04;
  localparam logic [7:0] BANK_STAT_OFF = 8'h08;
  localparam logic [7:0] RET_SET_OFF = 8'h0c;
  localparam logic [7:0] RET_CLR_OFF = 8'h10;
  localparam logic [7:0] RET_STAT_OFF = 8'h14;
  localparam logic [7:0] NMI_SET_OFF = 8'h18;
  localparam logic [7:0] NMI_CLR_OFF = 8'h1c;
  localparam logic [7:0] NMI_STAT_OFF = 8'h20;
  localparam logic [7:0] GLITCH_OFF = 8'h24;
  localparam logic [7:0] HALT_SET_OFF = 8'h28;
  localparam logic [7:0] HALT_CLR_OFF = 8'h2c;
  localparam logic [7:0] HALT_STAT_OFF = 8'h30;

  // ********************************************************************
  // Widths and reset values
  // ********************************************************************
  localparam int NBANK = 8;
  localparam int NNMI = 4;
  localparam int NHALT = 16;
  localparam logic [7:0] BANK_RST = 8'h01;
  localparam logic [7:0] RET_RST = 8'h01;
  localparam logic [3:0] NMI_RST = 4'h0;
  localparam logic [15:0] HALT_RST = 16'h0000;
  localparam logic GLITCH_RST = 1'b1;
  localparam logic [2:0] TIER_MIN = 3'h1;

  // NMI source bit positions
  localparam int NMI_FROM_PIN = 0;
  localparam int NMI_FROM_POWER_CONTROL = 1;
  localparam int NMI_FROM_SUPPLY_SUPERVISOR = 2;
  localparam int NMI_FROM_CLOCK_SYSTEM = 3;

  // Halt-run mask bit positions (serial channels 3..10, 16-bit timers 12..15)
  localparam int HALT_RUN_DMA = 0;
  localparam int HALT_RUN_WATCHDOG = 1;
  localparam int HALT_RUN_CONVERTER = 2;
  localparam int HALT_RUN_WIDE_TIMER = 11;

  // Bank power and retention outputs handed to the memory logic
  typedef struct packed {
    logic [NBANK-1:0] power;
    logic [NBANK-1:0] retain;
  } bank_ctl_s;

endpackage

// *** design/tier_decode.sv ***
// Tier decoder: turns a bank number into thermometer masks
`timescale 1ns/1ps
`default_nettype none
module tier_decode
  import sysctl_pkg::*;
(
  input wire logic [2:0] tier, // Bank tier number
  output logic [NBANK-1:0] up_mask, // Banks at and below tier
  output logic [NBANK-1:0] down_mask // Banks at and above tier
);

  // ********************************************************************
  // Masks
  // ********************************************************************
  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : gen_bit
      assign up_mask[g] = (g <= int'(tier));
      assign down_mask[g] = (g >= int'(tier));
    end
  endgenerate

endmodule
`default_nettype wire

// *** design/sysctl_top.sv ***
// System control: SRAM bank power and retention, NMI gating, halt mask
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Disabling tier 1..7 powers down that bank and all higher ones.
// - Enabling tier 1..7 powers up that bank and all lower ones.
// - Bank 0 stays powered whatever software requests.
// - On deep low-power entry each bank with its select set is retained.
// - Retention selects for banks 1..7 are clear after reset.
// - Bank 0 retention is always active and cannot be changed.
// - Retention selects are set or cleared freely per bank in one write.
// - A register bit turns reset pin glitch suppression on or off.
// - A fault from an enabled source sets the NMI flag, not if disabled.
// - Four NMI sources, any combination changed in one write.
// - After reset all peripherals run at CPU halt; any may be stopped.
// - The halt mask covers sixteen peripherals, written in one access.
module sysctl_top
  import sysctl_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic deep_low_power_state, // Request to enter deep sleep
  input wire logic [NNMI-1:0] nmi_fault, // Fault events from sources
  input wire logic nmi_ack, // NMI handler clears flag
  output logic nmi_flag_q, // Sticky NMI flag
  output logic [NBANK-1:0] bank_power_q, // Bank power enables
  output logic [NBANK-1:0] bank_retain_q, // Banks held in retention
  output logic glitch_filter_q, // Reset pin glitch suppression on
  output logic [NHALT-1:0] halt_stop_q // Peripherals stopped at halt
);

  // ********************************************************************
  // Register state
  // ********************************************************************
  logic [NBANK-1:0] bank_en_q, bank_en_d;
  logic [NBANK-1:0] ret_sel_q, ret_sel_d;
  logic [NNMI-1:0] nmi_en_q, nmi_en_d;
  logic [NHALT-1:0] halt_mask_q, halt_mask_d;
  logic glitch_d;
  logic [2:0] lp_sync_q;
  logic [NNMI*3-1:0] flt_sync_q;
  logic nmi_flag_d;
  logic [31:0] prdata_d;
  logic [NBANK-1:0] up_mask, down_mask;
  bank_ctl_s ctl;

  // Bus strobes: setup is one cycle, access completes with zero waits
  wire setup_wr = psel && !penable && pwrite;
  wire setup_rd = psel && !penable && !pwrite;
  wire [2:0] tier = pwdata[2:0];
  wire tier_ok = (tier >= TIER_MIN);

  // Address decode
  wire hit_en = (paddr == BANK_EN_OFF);
  wire hit_dis = (paddr == BANK_DIS_OFF);
  wire hit_rset = (paddr == RET_SET_OFF);
  wire hit_rclr = (paddr == RET_CLR_OFF);
  wire hit_nset = (paddr == NMI_SET_OFF);
  wire hit_nclr = (paddr == NMI_CLR_OFF);
  wire hit_gl = (paddr == GLITCH_OFF);
  wire hit_hset = (paddr == HALT_SET_OFF);
  wire hit_hclr = (paddr == HALT_CLR_OFF);
  wire hit_known = hit_en || hit_dis || hit_rset || hit_rclr ||
    hit_nset || hit_nclr || hit_gl || hit_hset || hit_hclr ||
    (paddr == BANK_STAT_OFF) || (paddr == RET_STAT_OFF) ||
    (paddr == NMI_STAT_OFF) || (paddr == HALT_STAT_OFF);

  tier_decode u_tier (
    .tier(tier),
    .up_mask(up_mask),
    .down_mask(down_mask)
  );

  // ********************************************************************
  // Next-state of software controls, taken in the setup cycle
  // ********************************************************************
  // Tier value 0 is refused so bank 0 can never be touched
  always_comb begin
    bank_en_d = bank_en_q;
    if (setup_wr && hit_en && tier_ok) begin
      bank_en_d = bank_en_q | up_mask;
    end else if (setup_wr && hit_dis && tier_ok) begin
      bank_en_d = bank_en_q & ~down_mask;
    end
    bank_en_d[0] = 1'b1;
  end

  // Retention selects are a plain bit set/clear, no tier coupling
  always_comb begin
    ret_sel_d = ret_sel_q;
    if (setup_wr && hit_rset) begin
      ret_sel_d = ret_sel_q | pwdata[NBANK-1:0];
    end else if (setup_wr && hit_rclr) begin
      ret_sel_d = ret_sel_q & ~pwdata[NBANK-1:0];
    end
    ret_sel_d[0] = 1'b1;
  end

  // NMI source enables
  always_comb begin
    nmi_en_d = nmi_en_q;
    if (setup_wr && hit_nset) begin
      nmi_en_d = nmi_en_q | pwdata[NNMI-1:0];
    end else if (setup_wr && hit_nclr) begin
      nmi_en_d = nmi_en_q & ~pwdata[NNMI-1:0];
    end
  end

  // Halt mask: a set bit stops that peripheral when the CPU halts
  always_comb begin
    halt_mask_d = halt_mask_q;
    if (setup_wr && hit_hset) begin
      halt_mask_d = halt_mask_q | pwdata[NHALT-1:0];
    end else if (setup_wr && hit_hclr) begin
      halt_mask_d = halt_mask_q & ~pwdata[NHALT-1:0];
    end
  end

  assign glitch_d = (setup_wr && hit_gl) ? pwdata[0] : glitch_filter_q;

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_en_q <= BANK_RST;
      ret_sel_q <= RET_RST;
      nmi_en_q <= NMI_RST;
      halt_mask_q <= HALT_RST;
      glitch_filter_q <= GLITCH_RST;
    end else begin
      bank_en_q <= bank_en_d;
      ret_sel_q <= ret_sel_d;
      nmi_en_q <= nmi_en_d;
      halt_mask_q <= halt_mask_d;
      glitch_filter_q <= glitch_d;
    end
  end

  // ********************************************************************
  // Input synchronisers (three stages, change needs stages 2 and 3 agree)
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_sync_q <= 3'h0;
      flt_sync_q <= '0;
    end else begin
      lp_sync_q <= {lp_sync_q[1:0], deep_low_power_state};
      for (int i = 0; i < NNMI; i++) begin
        flt_sync_q[i*3 +: 3] <= {flt_sync_q[i*3 +: 2], nmi_fault[i]};
      end
    end
  end

  // Filtered levels: hold last state until the late stages agree
  logic lp_lvl_q;
  logic [NNMI-1:0] flt_lvl_q;
  logic [NNMI-1:0] flt_agree;
  logic [NNMI-1:0] flt_new;
  wire lp_agree = (lp_sync_q[1] == lp_sync_q[2]);
  genvar gi;
  generate
    for (gi = 0; gi < NNMI; gi++) begin : gen_flt
      assign flt_agree[gi] = flt_sync_q[gi*3+1] == flt_sync_q[gi*3+2];
      assign flt_new[gi] = flt_agree[gi] ? flt_sync_q[gi*3+2] :
        flt_lvl_q[gi];
    end
  endgenerate
  wire lp_new = lp_agree ? lp_sync_q[2] : lp_lvl_q;
  wire [NNMI-1:0] flt_rise = flt_new & ~flt_lvl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_lvl_q <= 1'b0;
      flt_lvl_q <= '0;
    end else begin
      lp_lvl_q <= lp_new;
      flt_lvl_q <= flt_new;
    end
  end

  // ********************************************************************
  // NMI flag: set beats acknowledge in the same cycle
  // ********************************************************************
  wire nmi_set = |(flt_rise & nmi_en_q);
  assign nmi_flag_d = nmi_set ? 1'b1 : (nmi_ack ? 1'b0 : nmi_flag_q);

  // ********************************************************************
  // Outputs to memory and clock logic
  // ********************************************************************
  // Retention only applies while in deep sleep; bank 0 always retained
  always_comb begin
    ctl.power = bank_en_d;
    ctl.retain = lp_new ? ret_sel_d : RET_RST;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_flag_q <= 1'b0;
      bank_power_q <= BANK_RST;
      bank_retain_q <= RET_RST;
      halt_stop_q <= HALT_RST;
    end else begin
      nmi_flag_q <= nmi_flag_d;
      bank_power_q <= ctl.power;
      bank_retain_q <= ctl.retain;
      halt_stop_q <= halt_mask_d;
    end
  end

  // ********************************************************************
  // APB read data and error, prepared in the setup cycle
  // ********************************************************************
  always_comb begin
    prdata_d = 32'h0;
    if (paddr == BANK_STAT_OFF) begin
      prdata_d[NBANK-1:0] = bank_en_q;
    end else if (paddr == RET_STAT_OFF) begin
      prdata_d[NBANK-1:0] = ret_sel_q;
    end else if (paddr == NMI_STAT_OFF) begin
      prdata_d[NNMI-1:0] = nmi_en_q;
    end else if (paddr == GLITCH_OFF) begin
      prdata_d[0] = glitch_filter_q;
    end else if (paddr == HALT_STAT_OFF) begin
      prdata_d[NHALT-1:0] = halt_mask_q;
    end
  end

  // Ready in every access phase; unmapped address answers with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_known;
      if (setup_rd) begin
        prdata <= prdata_d;
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  property p_bank0_on;
    @(posedge pclk) disable iff (!presetn) bank_power_q[0];
  endproperty
  a_bank0_on: assert property (p_bank0_on)
    else $error("bank zero lost power");

  property p_thermo;
    @(posedge pclk) disable iff (!presetn)
      ((bank_en_q + 8'h01) & bank_en_q) == 8'h00;
  endproperty
  a_thermo: assert property (p_thermo)
    else $error("bank enables not contiguous");

  // Disable mask of the setup cycle, kept one edge for the check below
  logic [NBANK-1:0] down_mask_p;
  always_ff @(posedge pclk) down_mask_p <= down_mask;

  property p_dis;
    @(posedge pclk) disable iff (!presetn)
      setup_wr && hit_dis && tier_ok |=> (bank_en_q & down_mask_p) == 8'h00;
  endproperty
  a_dis: assert property (p_dis)
    else $error("disable left upper bank on");

  property p_en;
    @(posedge pclk) disable iff (!presetn)
      setup_wr && hit_en && tier_ok |=> &(bank_en_q | ~$past(up_mask));
  endproperty
  a_en: assert property (p_en)
    else $error("enable left lower bank off");

  property p_ret0;
    @(posedge pclk) disable iff (!presetn) bank_retain_q[0] && ret_sel_q[0];
  endproperty
  a_ret0: assert property (p_ret0)
    else $error("bank zero retention dropped");

  property p_ret_idle;
    @(posedge pclk) disable iff (!presetn)
      !lp_lvl_q ##1 !lp_lvl_q |-> bank_retain_q == RET_RST;
  endproperty
  a_ret_idle: assert property (p_ret_idle)
    else $error("retention outside deep sleep");

  property p_nmi_block;
    @(posedge pclk) disable iff (!presetn)
      !nmi_flag_q && nmi_en_q == 4'h0 && !nmi_ack ##1 nmi_en_q == 4'h0
      |-> !nmi_flag_q;
  endproperty
  a_nmi_block: assert property (p_nmi_block)
    else $error("disabled source raised flag");

  property p_nmi_set;
    @(posedge pclk) disable iff (!presetn) nmi_set |=> nmi_flag_q;
  endproperty
  a_nmi_set: assert property (p_nmi_set)
    else $error("enabled fault lost");

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
      setup_wr && hit_hset |=> ##1 ($past(pwdata[15:0], 2) & ~halt_stop_q)
        == 16'h0;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt mask bits not set");

  c_dis: cover property (@(posedge pclk) setup_wr && hit_dis && tier_ok);
  c_nmi: cover property (@(posedge pclk) nmi_set);
  c_ret: cover property (@(posedge pclk) bank_retain_q[7]);

endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking testbench for the system control block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sysctl_pkg::*;
;
  // ******************************************************************
  // Signals and instance
  // ******************************************************************
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic deep_low_power_state, nmi_ack, nmi_flag_q, glitch_filter_q, er;
  logic [NNMI-1:0] nmi_fault;
  logic [NBANK-1:0] bank_power_q, bank_retain_q;
  logic [NHALT-1:0] halt_stop_q;
  int fail_count, checks_done;

  sysctl_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .deep_low_power_state(deep_low_power_state), .nmi_fault(nmi_fault),
    .nmi_ack(nmi_ack), .nmi_flag_q(nmi_flag_q),
    .bank_power_q(bank_power_q), .bank_retain_q(bank_retain_q),
    .glitch_filter_q(glitch_filter_q), .halt_stop_q(halt_stop_q));

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      fail_count++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a register, compare the whole word read back and check no error
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check({31'h0, er}, 32'h0);
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset();
    check({24'h0, bank_power_q}, 32'h01);
    rchk(RET_STAT_OFF, 32'h01);
    rchk(HALT_STAT_OFF, 32'h0);
    check({31'h0, glitch_filter_q}, 32'h1);
    $display("Test reset values done");
  endtask

  // Tier enables and disables, including tier 0 and a status write
  task automatic t_banks();
    apb(1'b1, BANK_EN_OFF, 32'h7);
    rchk(BANK_STAT_OFF, 32'hff);
    apb(1'b1, BANK_DIS_OFF, 32'h5);
    check({24'h0, bank_power_q}, 32'h1f);
    apb(1'b1, BANK_EN_OFF, 32'h0);
    apb(1'b1, BANK_DIS_OFF, 32'h0);
    rchk(BANK_STAT_OFF, 32'h1f);
    apb(1'b1, BANK_DIS_OFF, 32'h1);
    check({24'h0, bank_power_q}, 32'h01);
    apb(1'b1, BANK_EN_OFF, 32'h3);
    apb(1'b1, BANK_STAT_OFF, 32'h7);
    rchk(BANK_STAT_OFF, 32'h0f);
    $display("Test bank tiers done");
  endtask

  // Free per-bank retention, applied only in deep sleep
  task automatic t_retain();
    int n;
    apb(1'b1, RET_SET_OFF, 32'ha4);
    apb(1'b1, RET_CLR_OFF, 32'h05);
    rchk(RET_STAT_OFF, 32'ha1);
    check({24'h0, bank_retain_q}, 32'h01);
    deep_low_power_state <= 1'b1;
    for (n = 0; n < 10 && bank_retain_q !== 8'ha1; n++) @(posedge pclk);
    check({24'h0, bank_retain_q}, 32'ha1);
    deep_low_power_state <= 1'b0;
    for (n = 0; n < 10 && bank_retain_q !== 8'h01; n++) @(posedge pclk);
    check({24'h0, bank_retain_q}, 32'h01);
    $display("Test retention done");
  endtask

  // Source gating of the sticky flag
  task automatic t_nmi();
    int n;
    apb(1'b1, NMI_SET_OFF, 32'hf);
    apb(1'b1, NMI_CLR_OFF, 32'h6);
    rchk(NMI_STAT_OFF, 32'h9);
    nmi_fault <= 4'h2;
    repeat (10) @(posedge pclk);
    check({31'h0, nmi_flag_q}, 32'h0);
    nmi_fault <= 4'h3;
    for (n = 0; n < 10 && nmi_flag_q !== 1'b1; n++) @(posedge pclk);
    check({31'h0, nmi_flag_q}, 32'h1);
    nmi_fault <= 4'h0;
    nmi_ack <= 1'b1;
    @(posedge pclk);
    nmi_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    check({31'h0, nmi_flag_q}, 32'h0);
    // All sources off: faults on every input must leave the flag clear
    apb(1'b1, NMI_CLR_OFF, 32'hf);
    rchk(NMI_STAT_OFF, 32'h0);
    nmi_fault <= 4'hf;
    repeat (10) @(posedge pclk);
    check({31'h0, nmi_flag_q}, 32'h0);
    nmi_fault <= 4'h0;
    $display("Test interrupt sources done");
  endtask

  // Glitch filter, halt mask and an unmapped address
  task automatic t_misc();
    apb(1'b1, GLITCH_OFF, 32'h0);
    rchk(GLITCH_OFF, 32'h0);
    check({31'h0, glitch_filter_q}, 32'h0);
    apb(1'b1, GLITCH_OFF, 32'h1);
    rchk(GLITCH_OFF, 32'h1);
    check({31'h0, glitch_filter_q}, 32'h1);
    // Leave it off so the later reset has something to restore
    apb(1'b1, GLITCH_OFF, 32'h0);
    apb(1'b1, HALT_SET_OFF, 32'hf00f);
    apb(1'b1, HALT_CLR_OFF, 32'h000f);
    rchk(HALT_STAT_OFF, 32'hf000);
    check({16'h0, halt_stop_q}, 32'hf000);
    apb(1'b0, 8'h3c, 32'h0);
    check({31'h0, er}, 32'h1);
    $display("Test glitch, halt mask and decode done");
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    fail_count = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    deep_low_power_state = 1'b0;
    nmi_fault = 4'h0;
    nmi_ack = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_banks();
    t_retain();
    t_nmi();
    t_misc();
    // Reset in mid-run must restore bank power, retention selects, halt mask and glitch filter to reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
